// ### touch_iteration.sv
// one iteration of the per-sensor touch algorithm on one count
// assumes start is a one-cycle pulse with its operands held that cycle
module touch_iteration #(
    parameter logic [15:0] THRESHOLD = touch_state_pkg::DEF_THRESHOLD,
    parameter logic [7:0]  DET_LIMIT = touch_state_pkg::DEF_DET_LIMIT
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        start,
    input  wire logic [4:0]  sensor,
    input  wire logic [15:0] count,
    input  wire logic        skipCal,
    input  wire logic [7:0]  detection_counter,
    input  wire logic [15:0] baseline_count,
    output logic             done,
    output logic [4:0]       resSensor,
    output logic             resSkip,
    output logic [7:0]       resDet,
    output logic [15:0]      resBase,
    output logic             resPushed
);

    logic        done_ff;
    logic        nxt_done;
    logic [4:0]  sensor_ff;
    logic [4:0]  nxt_sensor;
    logic        skip_ff;
    logic        nxt_skip;
    logic [7:0]  det_ff;
    logic [7:0]  nxt_det;
    logic [15:0] base_ff;
    logic [15:0] nxt_base;
    logic        pushed_ff;
    logic        nxt_pushed;
    logic [15:0] drop;
    logic [7:0]  detInc;

    ////////////////////////////////////////////////////////////////////
    // a touch adds load and so lowers the count below the baseline
    always_comb begin
        drop       = baseline_count - count;
        detInc     = (detection_counter == 8'hff) ? detection_counter : detection_counter + 8'h01;
        nxt_done   = start;
        nxt_sensor = sensor_ff;
        nxt_skip   = skip_ff;
        nxt_det    = det_ff;
        nxt_base   = base_ff;
        nxt_pushed = pushed_ff;
        if (start) begin
            nxt_sensor = sensor;
            if (!skipCal) begin
                nxt_base   = count;
                nxt_det    = 8'h00;
                nxt_skip   = 1'b1;
                nxt_pushed = 1'b0;
            end else if (count < baseline_count && drop >= THRESHOLD) begin
                nxt_det    = detInc;
                nxt_pushed = (detInc >= DET_LIMIT);
                nxt_base   = baseline_count;
                nxt_skip   = 1'b1;
            end else begin
                nxt_det    = 8'h00;
                nxt_pushed = 1'b0;
                nxt_skip   = 1'b1;
                // slow drift keeps the idle average, one step a pass
                if (count > baseline_count) begin
                    nxt_base = baseline_count + 16'h0001;
                end else if (count < baseline_count) begin
                    nxt_base = baseline_count - 16'h0001;
                end else begin
                    nxt_base = baseline_count;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            done_ff   <= 1'b0;
            sensor_ff <= 5'h00;
            skip_ff   <= 1'b0;
            det_ff    <= 8'h00;
            base_ff   <= 16'h0000;
            pushed_ff <= 1'b0;
        end else if (ce) begin
            done_ff   <= nxt_done;
            sensor_ff <= nxt_sensor;
            skip_ff   <= nxt_skip;
            det_ff    <= nxt_det;
            base_ff   <= nxt_base;
            pushed_ff <= nxt_pushed;
        end
    end

    assign done      = done_ff;
    assign resSensor = sensor_ff;
    assign resSkip   = skip_ff;
    assign resDet    = det_ff;
    assign resBase   = base_ff;
    assign resPushed = pushed_ff;

endmodule // touch_iteration

// ### touch_state_pkg.sv
// touch state register bank: offsets, field layout, reset values
// assumes an apb slave with byte addresses and one word per register
package touch_state_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    ////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFF_PAD_RES    = 8'h68;
    localparam logic [7:0] OFF_BASE_CNT   = 8'h6c;
    localparam logic [7:0] OFF_CURR_CNT   = 8'h70;
    localparam logic [7:0] OFF_STATE_WR   = 8'h78;
    localparam logic [7:0] OFF_STATE_RD   = 8'h7c;
    localparam logic [7:0] OFF_PUSHED     = 8'ha0;

    ////////////////////////////////////////////////////////////////////
    // field layout
    localparam int RES_W      = 17;
    localparam int COUNT_W    = 16;
    localparam int SKIP_BIT   = 24;
    localparam int DET_LSB    = 16;
    localparam int DET_W      = 8;
    localparam int BASE_LSB   = 0;
    localparam int BASE_W     = 16;
    localparam int SENSOR_W   = 5;
    localparam int SENSORS    = 32;

    ////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [RES_W-1:0]   RST_PAD_RES = 17'h00000;
    localparam logic [DATA_W-1:0]  RST_STATE   = 32'h00000000;
    localparam logic [SENSORS-1:0] RST_PUSHED  = 32'h00000000;

    ////////////////////////////////////////////////////////////////////
    // iteration defaults
    localparam logic [BASE_W-1:0] DEF_THRESHOLD = 16'h0010;
    localparam logic [DET_W-1:0]  DEF_DET_LIMIT = 8'h04;

endpackage

// ### touch_state_register_bank.sv
// apb register bank of the touch controller tail: pad group b
// resistive drive, autonomous count views, touch state and status
// assumes apb signals synchronous to clock, one word per register
//
// Our own choice: the APB interface to the registers.
module touch_state_register_bank #(
    parameter logic [15:0] THRESHOLD = touch_state_pkg::DEF_THRESHOLD,
    parameter logic [7:0]  DET_LIMIT = touch_state_pkg::DEF_DET_LIMIT
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        burstPhase,
    input  wire logic [15:0] baseCount,
    input  wire logic [15:0] currentCount,
    input  wire logic        acqValid,
    input  wire logic [4:0]  acqSensor,
    input  wire logic [15:0] acqCount,
    output logic [16:0]      senseePadGroupBResistive,
    output logic [31:0]      sensorPushed,
    output logic             iterationDone
);

    localparam int DW = touch_state_pkg::DATA_W;

    ////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic isMapped(input logic [7:0] a);
        if (a == touch_state_pkg::OFF_PAD_RES) begin
            isMapped = 1'b1;
        end else if (a == touch_state_pkg::OFF_BASE_CNT) begin
            isMapped = 1'b1;
        end else if (a == touch_state_pkg::OFF_CURR_CNT) begin
            isMapped = 1'b1;
        end else if (a == touch_state_pkg::OFF_STATE_WR) begin
            isMapped = 1'b1;
        end else if (a == touch_state_pkg::OFF_STATE_RD) begin
            isMapped = 1'b1;
        end else if (a == touch_state_pkg::OFF_PUSHED) begin
            isMapped = 1'b1;
        end else begin
            isMapped = 1'b0;
        end
    endfunction

    // byte lanes not strobed keep their old contents
    function automatic logic [31:0] laneMerge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  strb
    );
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        laneMerge = m;
    endfunction

    function automatic logic [31:0] packState(
        input logic        s,
        input logic [7:0]  d,
        input logic [15:0] b
    );
        logic [31:0] w;
        w = 32'h00000000;
        w[touch_state_pkg::SKIP_BIT] = s;
        w[touch_state_pkg::DET_LSB +: touch_state_pkg::DET_W] = d;
        w[touch_state_pkg::BASE_LSB +: touch_state_pkg::BASE_W] = b;
        packState = w;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic        ack_ff;
    logic        nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        err_ff;
    logic        nxt_err;
    logic [16:0] padRes_ff;
    logic [16:0] nxt_padRes;
    logic [31:0] stateWr_ff;
    logic [31:0] nxt_stateWr;
    logic [31:0] stateRd_ff;
    logic [31:0] nxt_stateRd;
    logic [31:0] pushed_ff;
    logic [31:0] nxt_pushed;
    logic [16:0] padOut_ff;
    logic [16:0] nxt_padOut;
    logic        access;
    logic        wrTake;
    logic [31:0] stateMask;
    logic [31:0] padMerge;
    logic        itDone;
    logic [4:0]  itSensor;
    logic        itSkip;
    logic [7:0]  itDet;
    logic [15:0] itBase;
    logic        itPushed;

    // only the three documented fields are storage; the rest reads zero
    assign stateMask = packState(1'b1, 8'hff, 16'hffff);

    // a function result cannot be part-selected, so merge into a net
    assign padMerge = laneMerge({15'h0000, padRes_ff}, pwdata, pstrb);

    ////////////////////////////////////////////////////////////////////
    // apb handshake: one wait state, read data taken into a flop

    assign access = psel && penable;
    assign wrTake = access && ack_ff && pwrite;

    always_comb begin
        nxt_ack   = 1'b0;
        nxt_rdata = rdata_ff;
        nxt_err   = err_ff;
        if (access && !ack_ff) begin
            nxt_ack = 1'b1;
            nxt_err = !isMapped(paddr);
            nxt_rdata = 32'h00000000;
            if (!pwrite) begin
                if (paddr == touch_state_pkg::OFF_PAD_RES) begin
                    nxt_rdata[16:0] = padRes_ff;
                end else if (paddr == touch_state_pkg::OFF_BASE_CNT) begin
                    nxt_rdata[15:0] = baseCount;
                end else if (paddr == touch_state_pkg::OFF_CURR_CNT) begin
                    nxt_rdata[15:0] = currentCount;
                end else if (paddr == touch_state_pkg::OFF_STATE_WR) begin
                    nxt_rdata = 32'h00000000;
                end else if (paddr == touch_state_pkg::OFF_STATE_RD) begin
                    nxt_rdata = stateRd_ff;
                end else if (paddr == touch_state_pkg::OFF_PUSHED) begin
                    nxt_rdata = pushed_ff;
                end else begin
                    nxt_rdata = 32'h00000000;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h00000000;
            err_ff   <= 1'b0;
        end else if (ce) begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
            err_ff   <= nxt_err;
        end
    end

    // a frozen block must not complete a transfer it cannot store
    assign pready  = ack_ff && ce;
    assign prdata  = rdata_ff;
    assign pslverr = ack_ff && ce && err_ff;

    ////////////////////////////////////////////////////////////////////
    // software registers and iteration results

    always_comb begin
        nxt_padRes  = padRes_ff;
        nxt_stateWr = stateWr_ff;
        nxt_stateRd = stateRd_ff;
        nxt_pushed  = pushed_ff;
        if (wrTake) begin
            if (paddr == touch_state_pkg::OFF_PAD_RES) begin
                nxt_padRes = padMerge[16:0];
            end else if (paddr == touch_state_pkg::OFF_STATE_WR) begin
                nxt_stateWr = laneMerge(stateWr_ff, pwdata, pstrb)
                              & stateMask;
            end else if (paddr == touch_state_pkg::OFF_STATE_RD) begin
                nxt_stateRd = laneMerge(stateRd_ff, pwdata, pstrb)
                              & stateMask;
            end else begin
                // count views and status ignore writes
                nxt_pushed = pushed_ff;
            end
        end
        // the iteration result wins over a software write in one cycle
        if (itDone) begin
            nxt_stateRd = packState(itSkip, itDet, itBase);
            nxt_pushed[itSensor] = itPushed;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            padRes_ff  <= touch_state_pkg::RST_PAD_RES;
            stateWr_ff <= touch_state_pkg::RST_STATE;
            stateRd_ff <= touch_state_pkg::RST_STATE;
            pushed_ff  <= touch_state_pkg::RST_PUSHED;
        end else if (ce) begin
            padRes_ff  <= nxt_padRes;
            stateWr_ff <= nxt_stateWr;
            stateRd_ff <= nxt_stateRd;
            pushed_ff  <= nxt_pushed;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // iteration engine: works on the state last written by software

    touch_iteration #(
        .THRESHOLD (THRESHOLD),
        .DET_LIMIT (DET_LIMIT)
    ) u_iteration (
        .clock     (clock),
        .reset     (reset),
        .ce        (ce),
        .start     (acqValid),
        .sensor    (acqSensor),
        .count     (acqCount),
        .skipCal   (stateWr_ff[touch_state_pkg::SKIP_BIT]),
        .detection_counter    (stateWr_ff[touch_state_pkg::DET_LSB +:
                               touch_state_pkg::DET_W]),
        .baseline_count   (stateWr_ff[touch_state_pkg::BASE_LSB +:
                               touch_state_pkg::BASE_W]),
        .done      (itDone),
        .resSensor (itSensor),
        .resSkip   (itSkip),
        .resDet    (itDet),
        .resBase   (itBase),
        .resPushed (itPushed)
    );

    ////////////////////////////////////////////////////////////////////
    // pad drive: resistive only while a burst runs, ordinary otherwise

    always_comb begin
        nxt_padOut = padRes_ff & {touch_state_pkg::RES_W{burstPhase}};
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            padOut_ff <= touch_state_pkg::RST_PAD_RES;
        end else if (ce) begin
            padOut_ff <= nxt_padOut;
        end
    end

    assign senseePadGroupBResistive = padOut_ff;
    assign sensorPushed             = pushed_ff;
    assign iterationDone            = itDone;

endmodule // touch_state_register_bank

// ### touch_state_register_bank_assertions.sv
// concurrent checks on the touch state register bank ports
// assumes one clock domain and the bank's one-wait-state apb timing
module touch_state_register_bank_assertions #(
    parameter logic [15:0] THRESHOLD = touch_state_pkg::DEF_THRESHOLD,
    parameter logic [7:0]  DET_LIMIT = touch_state_pkg::DEF_DET_LIMIT
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        burstPhase,
    input wire logic [15:0] baseCount,
    input wire logic [15:0] currentCount,
    input wire logic        acqValid,
    input wire logic [16:0] senseePadGroupBResistive,
    input wire logic        iterationDone
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    logic rdDone;
    assign rdDone = pready && !pwrite;

    ////////////////////////////////////////////////////////////////////
    a_ready_in_access: assert property (pready |-> psel && penable
        && $past(psel && penable)) else $error("ready outside access");
    a_ready_wait: assert property ($rose(penable) && psel |-> !pready)
        else $error("no wait state");
    a_err_unmapped: assert property (pready |-> pslverr == !(paddr inside
        {8'h68, 8'h6c, 8'h70, 8'h78, 8'h7c, 8'ha0}))
        else $error("error flag wrong");
    a_unmapped_zero: assert property (rdDone && pslverr |-> prdata == 0)
        else $error("unmapped read not zero");
    a_pad_idle: assert property (!burstPhase && ce |=>
        senseePadGroupBResistive == 17'h0) else $error("pad outside burst");
    a_done_follows: assert property (acqValid && ce |=> iterationDone)
        else $error("iteration not done");
    a_done_cause: assert property (iterationDone |-> $past(acqValid && ce))
        else $error("spurious done");
    a_base_view: assert property (rdDone && paddr == 8'h6c |->
        prdata == {16'h0, $past(baseCount)}) else $error("base view");
    a_curr_view: assert property (rdDone && paddr == 8'h70 |->
        prdata == {16'h0, $past(currentCount)}) else $error("current view");
    a_wo_zero: assert property (rdDone && paddr == 8'h78 |-> prdata == 0)
        else $error("write-only reads nonzero");
    a_state_fields: assert property (rdDone && paddr == 8'h7c |->
        prdata[31:25] == 7'h0) else $error("state spare bits set");

    c_error: cover property (pready && pslverr);
    c_iteration: cover property (acqValid ##1 iterationDone);
    c_burst: cover property (burstPhase ##1 senseePadGroupBResistive != 0);
endmodule // touch_state_register_bank_assertions

bind touch_state_register_bank touch_state_register_bank_assertions #(
    .THRESHOLD(THRESHOLD), .DET_LIMIT(DET_LIMIT)
) touch_state_register_bank_assertions_inst (
    .clock, .reset, .ce, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .burstPhase, .baseCount, .currentCount,
    .acqValid, .senseePadGroupBResistive, .iterationDone
);

// ### touch_state_register_bank_tb.sv
// self-checking bench for the touch state register bank
// assumes default iteration thresholds and the apb tasks below
module touch_state_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end

    logic        clock, reset, ce, psel, penable, pwrite, pready, pslverr;
    logic        burstPhase, acqValid, iterationDone, er;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [4:0]  acqSensor;
    logic [15:0] baseCount, currentCount, acqCount;
    logic [16:0] senseePadGroupBResistive;
    logic [31:0] pwdata, prdata, sensorPushed, rd, expPushed;
    int          n_mismatch = 0;
    int          n_tests = 0;
    // iteration table: state written, sensor, count, state read, pushed
    logic [31:0] tw[6] = '{32'h0, 32'h01020100, 32'h01030100,
                           32'h01ff0100, 32'h01050100, 32'h01050100};
    logic [4:0]  ts[6] = '{5'h03, 5'h03, 5'h03, 5'h1f, 5'h03, 5'h1f};
    logic [15:0] tc[6] = '{16'h0100, 16'h0080, 16'h0080,
                           16'h00f0, 16'h0104, 16'h00f1};
    logic [31:0] te[6] = '{32'h01000100, 32'h01030100, 32'h01040100,
                           32'h01ff0100, 32'h01000101, 32'h010000ff};
    logic        tp[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

    touch_state_register_bank touch_state_register_bank_inst (
        .clock, .reset, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .burstPhase, .baseCount,
        .currentCount, .acqValid, .acqSensor, .acqCount,
        .senseePadGroupBResistive, .sensorPushed, .iterationDone
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////
    // one apb transfer; an idle cycle first keeps drivers single-assigned
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        // pready, prdata and pslverr are taken at the completing edge
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) n_mismatch++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic ee);
        apb(1'b1, a, d, s);
        `CHK(er, ee)
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                       input logic ee);
        apb(1'b0, a, 32'h0, 4'h0);
        `CHK(rd, x)
        `CHK(er, ee)
    endtask

    task automatic iter(input logic [4:0] s, input logic [15:0] c);
        @(posedge clock);
        acqSensor <= s;
        acqCount <= c;
        acqValid <= 1'b1;
        @(posedge clock);
        acqValid <= 1'b0;
        #1 `CHK(iterationDone, 1'b1)
    endtask

    task summarize;
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, burstPhase, acqValid} = 5'h00;
        {paddr, pstrb, acqSensor, acqCount} = 33'h0;
        pwdata = 32'h0;
        baseCount = 16'h1234;
        currentCount = 16'h5678;
        ce = 1'b1;
        reset = 1'b1;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        rdc(8'h68, 32'h0, 1'b0);
        rdc(8'h7c, 32'h0, 1'b0);
        rdc(8'ha0, 32'h0, 1'b0);
        wr(8'h6c, 32'hffffffff, 4'hf, 1'b0);
        wr(8'h70, 32'hffffffff, 4'hf, 1'b0);
        wr(8'ha0, 32'hffffffff, 4'hf, 1'b0);
        rdc(8'h6c, 32'h00001234, 1'b0);
        rdc(8'h70, 32'h00005678, 1'b0);
        rdc(8'ha0, 32'h0, 1'b0);
        wr(8'h68, 32'hffffffff, 4'hf, 1'b0);
        rdc(8'h68, 32'h0001ffff, 1'b0);
        burstPhase <= 1'b1;
        repeat (2) @(posedge clock);
        #1 `CHK(senseePadGroupBResistive, 17'h1ffff)
        @(posedge clock);
        burstPhase <= 1'b0;
        repeat (2) @(posedge clock);
        #1 `CHK(senseePadGroupBResistive, 17'h0)
        wr(8'h68, 32'h0, 4'h1, 1'b0);
        rdc(8'h68, 32'h0001ff00, 1'b0);
        wr(8'h04, 32'hffffffff, 4'hf, 1'b1);
        rdc(8'h04, 32'h0, 1'b1);
        wr(8'h7c, 32'hffffffff, 4'hf, 1'b0);
        rdc(8'h7c, 32'h01ffffff, 1'b0);
        wr(8'h78, 32'h01ab1234, 4'hf, 1'b0);
        rdc(8'h78, 32'h0, 1'b0);
        expPushed = 32'h0;
        for (int i = 0; i < 6; i++) begin
            wr(8'h78, tw[i], 4'hf, 1'b0);
            iter(ts[i], tc[i]);
            rdc(8'h7c, te[i], 1'b0);
            expPushed[ts[i]] = tp[i];
            rdc(8'ha0, expPushed, 1'b0);
            `CHK(sensorPushed, expPushed)
        end
        // a frozen bank must not take an acquisition
        @(posedge clock);
        ce <= 1'b0;
        acqValid <= 1'b1;
        @(posedge clock);
        acqValid <= 1'b0;
        ce <= 1'b1;
        #1 `CHK(iterationDone, 1'b0)
        rdc(8'h7c, te[5], 1'b0);
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rdc(8'h68, 32'h0, 1'b0);
        rdc(8'h7c, 32'h0, 1'b0);
        `CHK(sensorPushed, 32'h0)
        summarize();
    end
endmodule // touch_state_register_bank_tb
